// ---- common/pefc_map.vh ----
`ifndef PEFC_MAP_VH
`define PEFC_MAP_VH
// word offsets of the register words
`define PEFC_OFS_PE_FUNC     4'h0
`define PEFC_OFS_PF_DIR      4'h1
`define PEFC_OFS_PF_UPPER    4'h2
`define PEFC_OFS_MODE        4'h3
// reset values
`define PEFC_RST_PE_FUNC     5'h00
`define PEFC_RST_PF_DIR      16'h0000
`define PEFC_RST_PF_UPPER    16'h0015
// writable bits of the upper function select word
`define PEFC_UPPER_WMASK     16'hd555
// field positions in the upper function select word
`define PEFC_BIT_CLK_FLOAT   15
`define PEFC_BIT_PF15        14
`define PEFC_BIT_PF14        12
`define PEFC_BIT_PF13        10
`define PEFC_BIT_PF12        8
`define PEFC_BIT_PF11        6
`define PEFC_BIT_PF10        4
`define PEFC_BIT_PF9         2
`define PEFC_BIT_PF8         0
// operating modes
`define PEFC_MODE_EXP_NOROM  2'h0
`define PEFC_MODE_EXP_ROM    2'h1
`define PEFC_MODE_SINGLE     2'h2
`define PEFC_RD_LATENCY      1
`endif

// ---- design/pefc_pe_mux.v ----
`timescale 1ns/1ps
`include "pefc_map.vh"
module pefc_pe_mux (
	// control
	input  wire [1:0] mode_i,
	input  wire [4:0] func_i,
	// pin selection
	output wire [4:0] addr_sel_o
);
	genvar g;
	generate
		for (g = 0; g < 5; g = g + 1) begin : g_pin
			assign addr_sel_o[g] =
				(mode_i == `PEFC_MODE_EXP_NOROM) |
				((mode_i == `PEFC_MODE_EXP_ROM) & func_i[g]);
		end
	endgenerate
endmodule // pefc_pe_mux

// ---- design/pefc_pf_mux.v ----
`timescale 1ns/1ps
`include "pefc_map.vh"
module pefc_pf_mux (
	// control
	input  wire [1:0]  mode_i,
	input  wire [15:0] upper_i,
	// per-pin peripheral selection for pins 15..8
	output wire [7:0]  periph_sel_o
);
	wire expanded = (mode_i == `PEFC_MODE_EXP_NOROM) |
		(mode_i == `PEFC_MODE_EXP_ROM);
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_pin
			// function bit of pin 8+g sits at bit 2g
			assign periph_sel_o[g] = expanded & upper_i[2*g];
		end
	endgenerate
endmodule // pefc_pf_mux

// ---- design/pefc_top.v ----
`timescale 1ns/1ps
`include "pefc_map.vh"
// Functional notes
// - expanded ROM-off mode: port E pins 4..0 always drive address bits.
// - expanded ROM-on: function bit 0 gives general I/O, 1 address; reset 0.
// - single-chip: port E pins 4..0 are general I/O regardless of bits.
// - port F direction is 16-bit read/write, one bit per pin.
// - general I/O pin drives out when its direction bit is 1.
// - direction bit ignored when a peripheral or bus function is selected.
// - direction clears on power-on and hardware standby, not watchdog reset.
// - function selects load reset values on power-on and hardware standby.
// - upper select covers pins 15..8; 16-bit read/write register.
// - bit 15 zero drives system clock out, one floats it.
// - expanded: bit 14 makes pin 15 the bus request input.
// - expanded: bit 12 makes pin 14 the bus acknowledge output.
// - reserved odd bits read zero; software writes zero.
// - expanded: bit 10 makes pin 13 chip select three; resets 0.
// - expanded: bits 8 and 6 make pins 12, 11 chip selects two, one.
// - expanded: bits 4,2,0 select CS0, read strobe, wait input; reset 1.
module pefc_top (
	// clock and reset
	input  wire        MCLK_I,
	input  wire        SRST_I,
	// reset kinds and operating mode
	input  wire        POR_I,
	input  wire        WDT_POR_I,
	input  wire        HW_STANDBY_I,
	input  wire [1:0]  MODE_I,
	// avalon-mm slave
	input  wire [3:0]  AVS_ADDRESS_I,
	input  wire        AVS_READ_I,
	input  wire        AVS_WRITE_I,
	input  wire [31:0] AVS_WRITEDATA_I,
	input  wire [3:0]  AVS_BYTEENABLE_I,
	output reg  [31:0] AVS_READDATA_O,
	output reg         AVS_WAITREQUEST_O,
	// port e pins 4..0
	input  wire [4:0]  PE_PIN_I,
	output reg  [4:0]  PE_PIN_O,
	output reg  [4:0]  PE_PIN_OE_O,
	input  wire [4:0]  PE_GPIO_O_I,
	input  wire [4:0]  PE_GPIO_OE_I,
	input  wire [4:0]  ADDR_LOW_I,
	output reg  [4:0]  PE_GPIO_IN_O,
	// port f pins 15..0
	input  wire [15:0] PF_PIN_I,
	output reg  [15:0] PF_PIN_O,
	output reg  [15:0] PF_PIN_OE_O,
	input  wire [15:0] PF_GPIO_DATA_I,
	output reg  [15:0] PF_GPIO_IN_O,
	// bus functions of port f pins 15..8
	input  wire        BUS_ACK_I,
	input  wire [3:0]  CHIP_SELECT_I,
	input  wire        READ_STROBE_I,
	output reg         BUS_REQUEST_IN_O,
	output reg         WAIT_IN_O,
	// lower port f pins: peripheral select and drive from the lower unit
	input  wire [7:0]  PF_LOW_PERIPH_I,
	input  wire [7:0]  PF_LOW_PERIPH_O_I,
	input  wire [7:0]  PF_LOW_PERIPH_OE_I,
	// system clock pin
	input  wire        SYS_CLK_I,
	output reg         SYS_CLK_OUT_PIN_O,
	output reg         SYS_CLK_OUT_PIN_OE_O
);
	reg  [4:0]  pe_func_r;
	reg  [15:0] pf_dir_r;
	reg  [15:0] pf_upper_r;
	reg         ack_pend_r;
	reg  [31:0] rd_nxt;
	wire [4:0]  pe_addr_sel;
	wire [7:0]  pf_hi_sel;
	wire [15:0] pf_periph;
	wire        init_clr;
	wire        wr_go;
	wire        rd_go;

	// watchdog power-on reset leaves the pin registers alone
	assign init_clr = SRST_I | (POR_I & ~WDT_POR_I) | HW_STANDBY_I;
	// one wait cycle: the access completes on the edge after it is seen
	assign wr_go = AVS_WRITE_I & ack_pend_r;
	assign rd_go = AVS_READ_I & ack_pend_r;

	function [15:0] lane_merge;
		input [15:0] old;
		input [15:0] wd;
		input [1:0]  be;
		begin
			lane_merge = old;
			if (be[0])
				lane_merge[7:0] = wd[7:0];
			if (be[1])
				lane_merge[15:8] = wd[15:8];
		end
	endfunction

	pefc_pe_mux u_pe_mux (
		.mode_i     (MODE_I),
		.func_i     (pe_func_r),
		.addr_sel_o (pe_addr_sel)
	);

	pefc_pf_mux u_pf_mux (
		.mode_i       (MODE_I),
		.upper_i      (pf_upper_r),
		.periph_sel_o (pf_hi_sel)
	);

	assign pf_periph = {pf_hi_sel, PF_LOW_PERIPH_I};

	// bus handshake
	always @(posedge MCLK_I) begin
		if (SRST_I) begin
			ack_pend_r        <= 1'b0;
			AVS_WAITREQUEST_O <= 1'b1;
			AVS_READDATA_O    <= 32'h00000000;
		end else begin
			ack_pend_r        <= (AVS_READ_I | AVS_WRITE_I) & ~ack_pend_r;
			AVS_WAITREQUEST_O <= ~((AVS_READ_I | AVS_WRITE_I) & ~ack_pend_r);
			if (AVS_READ_I & ~ack_pend_r)
				AVS_READDATA_O <= rd_nxt;
		end
	end

	always @* begin
		case (AVS_ADDRESS_I)
		`PEFC_OFS_PE_FUNC:
			rd_nxt = {27'h0000000, pe_func_r};
		`PEFC_OFS_PF_DIR:
			rd_nxt = {16'h0000, pf_dir_r};
		`PEFC_OFS_PF_UPPER:
			rd_nxt = {16'h0000, pf_upper_r & `PEFC_UPPER_WMASK};
		`PEFC_OFS_MODE:
			rd_nxt = {30'h00000000, MODE_I};
		default:
			rd_nxt = 32'h00000000;
		endcase
	end

	// registers
	always @(posedge MCLK_I) begin
		if (init_clr) begin
			pe_func_r  <= `PEFC_RST_PE_FUNC;
			pf_dir_r   <= `PEFC_RST_PF_DIR;
			pf_upper_r <= `PEFC_RST_PF_UPPER;
		end else if (wr_go) begin
			case (AVS_ADDRESS_I)
			`PEFC_OFS_PE_FUNC:
				if (AVS_BYTEENABLE_I[0])
					pe_func_r <= AVS_WRITEDATA_I[4:0];
			`PEFC_OFS_PF_DIR:
				pf_dir_r <= lane_merge(pf_dir_r, AVS_WRITEDATA_I[15:0],
					AVS_BYTEENABLE_I[1:0]);
			`PEFC_OFS_PF_UPPER:
				pf_upper_r <= lane_merge(pf_upper_r, AVS_WRITEDATA_I[15:0],
					AVS_BYTEENABLE_I[1:0]) & `PEFC_UPPER_WMASK;
			default: begin
			end
			endcase
		end
	end

	// pin next values; registered below so every pin output is a flop

	// port e
	reg  [4:0]  pe_o_nxt;
	reg  [4:0]  pe_oe_nxt;
	reg  [4:0]  pe_in_nxt;

	// port f
	reg  [15:0] pf_o_nxt;
	reg  [15:0] pf_oe_nxt;
	reg  [15:0] pf_in_nxt;

	// bus inputs taken from port f pins, and the clock pin
	reg         bus_request_in_nxt;
	reg         wait_nxt;
	reg         ck_oe_nxt;

	always @* begin
		// port e: address output where selected, general i/o elsewhere
		pe_o_nxt  = (pe_addr_sel & ADDR_LOW_I) |
			(~pe_addr_sel & PE_GPIO_O_I);
		pe_oe_nxt = pe_addr_sel | PE_GPIO_OE_I;
		pe_in_nxt = PE_PIN_I & ~pe_addr_sel;

		// port f general i/o: the direction bit decides the drive
		pf_o_nxt  = PF_GPIO_DATA_I;
		pf_oe_nxt = pf_dir_r;
		pf_in_nxt = PF_PIN_I;
		bus_request_in_nxt  = 1'b0;
		wait_nxt  = 1'b0;

		// lower pins follow the lower function unit when it claims them
		pf_o_nxt[7:0]  = (~pf_periph[7:0] & PF_GPIO_DATA_I[7:0]) |
			(pf_periph[7:0] & PF_LOW_PERIPH_O_I);
		pf_oe_nxt[7:0] = (~pf_periph[7:0] & pf_dir_r[7:0]) |
			(pf_periph[7:0] & PF_LOW_PERIPH_OE_I);
		pf_in_nxt[7:0] = PF_PIN_I[7:0] & ~pf_periph[7:0];

		// pin 15: bus request is an input, direction bit ignored
		if (pf_periph[15]) begin
			pf_o_nxt[15]  = 1'b0;
			pf_oe_nxt[15] = 1'b0;
			pf_in_nxt[15] = 1'b0;
			bus_request_in_nxt      = PF_PIN_I[15];
		end

		// pin 14: bus acknowledge output
		if (pf_periph[14]) begin
			pf_o_nxt[14]  = BUS_ACK_I;
			pf_oe_nxt[14] = 1'b1;
			pf_in_nxt[14] = 1'b0;
		end

		// pin 13: chip select three
		if (pf_periph[13]) begin
			pf_o_nxt[13]  = CHIP_SELECT_I[3];
			pf_oe_nxt[13] = 1'b1;
			pf_in_nxt[13] = 1'b0;
		end

		// pin 12: chip select two
		if (pf_periph[12]) begin
			pf_o_nxt[12]  = CHIP_SELECT_I[2];
			pf_oe_nxt[12] = 1'b1;
			pf_in_nxt[12] = 1'b0;
		end

		// pin 11: chip select one
		if (pf_periph[11]) begin
			pf_o_nxt[11]  = CHIP_SELECT_I[1];
			pf_oe_nxt[11] = 1'b1;
			pf_in_nxt[11] = 1'b0;
		end

		// pin 10: chip select zero
		if (pf_periph[10]) begin
			pf_o_nxt[10]  = CHIP_SELECT_I[0];
			pf_oe_nxt[10] = 1'b1;
			pf_in_nxt[10] = 1'b0;
		end

		// pin 9: read strobe output
		if (pf_periph[9]) begin
			pf_o_nxt[9]  = READ_STROBE_I;
			pf_oe_nxt[9] = 1'b1;
			pf_in_nxt[9] = 1'b0;
		end

		// pin 8: wait is an input, direction bit ignored
		if (pf_periph[8]) begin
			pf_o_nxt[8]  = 1'b0;
			pf_oe_nxt[8] = 1'b0;
			pf_in_nxt[8] = 1'b0;
			wait_nxt     = PF_PIN_I[8];
		end

		// clock pin floats while its bit is set
		ck_oe_nxt = ~pf_upper_r[`PEFC_BIT_CLK_FLOAT];
	end

	// pins
	always @(posedge MCLK_I) begin
		if (SRST_I) begin
			PE_PIN_O             <= 5'h00;
			PE_PIN_OE_O          <= 5'h00;
			PE_GPIO_IN_O         <= 5'h00;
			PF_PIN_O             <= 16'h0000;
			PF_PIN_OE_O          <= 16'h0000;
			PF_GPIO_IN_O         <= 16'h0000;
			BUS_REQUEST_IN_O     <= 1'b0;
			WAIT_IN_O            <= 1'b0;
			SYS_CLK_OUT_PIN_O    <= 1'b0;
			SYS_CLK_OUT_PIN_OE_O <= 1'b0;
		end else begin
			PE_PIN_O             <= pe_o_nxt;
			PE_PIN_OE_O          <= pe_oe_nxt;
			PE_GPIO_IN_O         <= pe_in_nxt;
			PF_PIN_O             <= pf_o_nxt;
			PF_PIN_OE_O          <= pf_oe_nxt;
			PF_GPIO_IN_O         <= pf_in_nxt;
			BUS_REQUEST_IN_O     <= bus_request_in_nxt;
			WAIT_IN_O            <= wait_nxt;
			SYS_CLK_OUT_PIN_O    <= SYS_CLK_I;
			SYS_CLK_OUT_PIN_OE_O <= ck_oe_nxt;
		end
	end
endmodule // pefc_top

// ---- dv/pefc_top_assertions.sv ----
`timescale 1ns/1ps
module pefc_chk (
	input wire        MCLK_I,
	input wire        SRST_I,
	input wire [1:0]  MODE_I,
	input wire [3:0]  AVS_ADDRESS_I,
	input wire        AVS_READ_I,
	input wire        AVS_WRITE_I,
	input wire [31:0] AVS_READDATA_O,
	input wire        AVS_WAITREQUEST_O,
	input wire [4:0]  PE_PIN_O,
	input wire [4:0]  PE_PIN_OE_O,
	input wire [4:0]  PE_GPIO_OE_I,
	input wire [4:0]  ADDR_LOW_I,
	input wire [15:0] PF_PIN_OE_O,
	input wire        BUS_REQUEST_IN_O,
	input wire        WAIT_IN_O
);
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (SRST_I);
	a_wait_answer: assert property ((AVS_READ_I || AVS_WRITE_I) &&
		AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O) else $error("no answer");
	a_wait_pulse: assert property (!AVS_WAITREQUEST_O |=>
		AVS_WAITREQUEST_O) else $error("answer too long");
	a_romoff_addr: assert property (MODE_I == 2'h0 |=> PE_PIN_OE_O == 5'h1f &&
		PE_PIN_O == $past(ADDR_LOW_I)) else $error("address pins wrong");
	a_single_gpio: assert property (MODE_I[1] |=>
		PE_PIN_OE_O == $past(PE_GPIO_OE_I)) else $error("port e not gpio");
	a_upper_rsvd: assert property (!AVS_WAITREQUEST_O && AVS_READ_I &&
		AVS_ADDRESS_I == 4'h2 |-> (AVS_READDATA_O & 32'hffff2aaa) == 32'h0)
		else $error("reserved bits set");
	a_dir_width: assert property (!AVS_WAITREQUEST_O && AVS_READ_I &&
		AVS_ADDRESS_I == 4'h1 |-> AVS_READDATA_O[31:16] == 16'h0)
		else $error("direction too wide");
	a_single_bus: assert property (MODE_I[1] |=>
		!BUS_REQUEST_IN_O && !WAIT_IN_O) else $error("bus input in single");
	a_bus_request_in_input: assert property (BUS_REQUEST_IN_O |->
		!PF_PIN_OE_O[15]) else $error("request pin driven");
endmodule // pefc_chk
bind pefc_top pefc_chk i_pefc_chk (.*);

// ---- dv/pefc_board.sv ----
`timescale 1ns/1ps
module pefc_board (
	// clock
	input  wire        clk_i,
	// port f pins
	input  wire [15:0] pf_o_i,
	input  wire [15:0] pf_oe_i,
	output wire [15:0] pf_i_o
);
	// undriven lines toggle so a stale level never passes
	reg [15:0] noise_r = 16'ha5c3;
	always @(posedge clk_i) begin
		noise_r <= ~noise_r;
	end
	assign pf_i_o = (pf_o_i & pf_oe_i) | (noise_r & ~pf_oe_i);
endmodule // pefc_board

// ---- dv/pefc_top_bench.sv ----
`timescale 1ns/1ps
module pefc_top_bench;
	reg         clk = 0, rst = 1, por = 0, wdt = 0, hws = 0, rd = 0, wr = 0;
	reg  [1:0]  mode = 2'h2;
	reg  [3:0]  adr = 4'h0;
	reg  [3:0]  be = 4'hf;
	reg  [4:0]  gpoe = 5'h00;
	reg  [15:0] wd = 16'h0;
	wire [31:0] rdata;
	wire        wreq, ckoe;
	wire [4:0]  peo, peoe;
	wire [15:0] pfo, pfoe, pfi;
	integer     miscompares = 0, compares = 0;
	pefc_top i_pefc_top (.MCLK_I(clk), .SRST_I(rst), .POR_I(por),
		.WDT_POR_I(wdt), .HW_STANDBY_I(hws), .MODE_I(mode),
		.AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
		.AVS_WRITEDATA_I({16'h0, wd}), .AVS_BYTEENABLE_I(be),
		.AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wreq), .PE_PIN_I(peo),
		.PE_PIN_O(peo), .PE_PIN_OE_O(peoe), .PE_GPIO_O_I(5'h0a),
		.PE_GPIO_OE_I(gpoe), .ADDR_LOW_I(wd[4:0]), .PE_GPIO_IN_O(),
		.PF_PIN_I(pfi), .PF_PIN_O(pfo), .PF_PIN_OE_O(pfoe),
		.PF_GPIO_DATA_I(~wd), .PF_GPIO_IN_O(), .BUS_ACK_I(mode[0]),
		.CHIP_SELECT_I(4'ha), .READ_STROBE_I(~mode[0]),
		.BUS_REQUEST_IN_O(), .WAIT_IN_O(), .PF_LOW_PERIPH_I(8'h00),
		.PF_LOW_PERIPH_O_I(8'h00), .PF_LOW_PERIPH_OE_I(8'h00),
		.SYS_CLK_I(clk), .SYS_CLK_OUT_PIN_O(), .SYS_CLK_OUT_PIN_OE_O(ckoe));
	pefc_board i_pefc_board (.clk_i(clk), .pf_o_i(pfo), .pf_oe_i(pfoe),
		.pf_i_o(pfi));
	task finish_test;
		begin
			$display("compares %0d miscompares %0d", compares, miscompares);
			if (miscompares == 0 && compares > 0)
				$display("verification passed");
			else
				$display("verification failed");
			$finish;
		end
	endtask
	task chk(input [31:0] g, input [31:0] e);
		begin
			compares = compares + 1;
			if (g !== e) begin
				miscompares = miscompares + 1;
				$display("BAD t=%0t got %h exp %h", $time, g, e);
			end
		end
	endtask
	task bus(input w, input [3:0] a, input [15:0] d, output [31:0] q);
		integer n;
		begin
			@(posedge clk);
			adr <= a;
			wd <= d;
			wr <= w;
			rd <= !w;
			n = 0;
			@(posedge clk);
			while (wreq !== 1'b0 && n < 20) begin
				@(posedge clk);
				n = n + 1;
			end
			q = rdata;
			wr <= 1'b0;
			rd <= 1'b0;
			if (wreq !== 1'b0) begin
				miscompares = miscompares + 1;
				finish_test;
			end
		end
	endtask
	task rdc(input [3:0] a, input [31:0] e);
		reg [31:0] q;
		begin
			bus(1'b0, a, 16'h0015, q);
			chk(q, e);
		end
	endtask
	task wrr(input [3:0] a, input [15:0] d);
		reg [31:0] q;
		begin
			bus(1'b1, a, d, q);
		end
	endtask
	task t_reset;
		begin
			rdc(4'h0, 32'h0);
			rdc(4'h1, 32'h0);
			rdc(4'h2, 32'h15);
			$display("reset values done");
		end
	endtask
	task t_single;
		begin
			wrr(4'h0, 16'h001f);
			wrr(4'h1, 16'ha5c3);
			wrr(4'h2, 16'hd555);
			wrr(4'h9, 16'hffff);
			rdc(4'h0, 32'h1f);
			rdc(4'h1, 32'ha5c3);
			rdc(4'h2, 32'hd555);
			rdc(4'h9, 32'h0);
			gpoe <= 5'h0c;
			repeat (3) @(posedge clk);
			chk(peoe, 5'h0c);
			chk(pfoe, 16'ha5c3);
			chk(pfo & pfoe, 16'ha5c2);
			$display("single-chip done");
		end
	endtask
	task t_exp;
		begin
			mode <= 2'h1;
			repeat (3) @(posedge clk);
			chk(peoe, 5'h1f);
			chk(peo, 5'h15);
			chk(pfoe[15:8], 8'h7e);
			chk(pfo[14:9], 6'h34);
			chk(ckoe, 1'b0);
			wrr(4'h0, 16'h0005);
			wrr(4'h2, 16'h8000);
			repeat (3) @(posedge clk);
			chk(peoe, 5'h0d);
			chk(pfoe[15:8], 8'ha5);
			chk(ckoe, 1'b0);
			mode <= 2'h0;
			repeat (3) @(posedge clk);
			chk(peoe, 5'h1f);
			$display("expanded done");
		end
	endtask
	task t_resets;
		begin
			por <= 1'b1;
			wdt <= 1'b1;
			@(posedge clk);
			por <= 1'b0;
			wdt <= 1'b0;
			rdc(4'h1, 32'ha5c3);
			rdc(4'h2, 32'h8000);
			hws <= 1'b1;
			@(posedge clk);
			hws <= 1'b0;
			rdc(4'h1, 32'h0);
			rdc(4'h2, 32'h15);
			chk(ckoe, 1'b1);
			be <= 4'h1;
			wrr(4'h1, 16'hffff);
			be <= 4'hf;
			rdc(4'h1, 32'h00ff);
			por <= 1'b1;
			@(posedge clk);
			por <= 1'b0;
			rdc(4'h1, 32'h0);
			$display("reset kinds done");
		end
	endtask
	initial begin
		forever #10 clk = ~clk;
	end
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_single;
		t_exp;
		t_resets;
		finish_test;
	end
endmodule // pefc_top_bench
